// >>> hw/ocf_defines.svh
// Command codes, field positions, reset values and timing counts for the over-current fault block
`ifndef OCF_DEFINES_SVH
`define OCF_DEFINES_SVH

`define OCF_CMD_ACTION     8'h47
`define OCF_CMD_LV_THRESH  8'h48
`define OCF_CMD_WARN       8'h4a
`define OCF_CMD_UNIT       8'hd2
`define OCF_CMD_STATUS     8'he0

`define OCF_RESP_HI        7
`define OCF_RESP_LO        6
`define OCF_RETRY_HI       5
`define OCF_RETRY_LO       3
`define OCF_DELAY_HI       2
`define OCF_DELAY_LO       0

`define OCF_RETRY_NONE     3'h0
`define OCF_RETRY_ENDLESS  3'h7

`define OCF_ACTION_RST     8'h00
`define OCF_LV_RST         16'h0000
`define OCF_WARN_RST       16'h7bff

`define OCF_CLK_MHZ        200
`define OCF_UNIT_NS        1000
`define OCF_UNIT_RST       16'((`OCF_UNIT_NS * `OCF_CLK_MHZ) / 1000)

`define OCF_STAT_FAULT     0
`define OCF_STAT_WARN      1
`define OCF_STAT_LATCHED   2
`define OCF_STAT_OUT_EN    3
`define OCF_STAT_LIMIT     4
`define OCF_STAT_ATT_LO    5

`endif

// >>> hw/ocf_pkg.sv
// Types shared by the over-current fault block
package ocf_pkg;

  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_RUN   = 6'h02,
    ST_LIMIT = 6'h04,
    ST_WAIT  = 6'h08,
    ST_LATCH = 6'h10,
    ST_HOLD  = 6'h20
  } ocf_state_e;

  typedef enum logic [1:0] {
    MODE_IGNORE  = 2'h0,
    MODE_COND_CC = 2'h1,
    MODE_DELAY   = 2'h2,
    MODE_RESUME  = 2'h3
  } ocf_mode_e;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [7:0] units;
    logic [15:0] cyc;
  } ocf_timer_s;

  typedef struct packed {
    ocf_state_e  st;
    logic [2:0]  attempts;
    logic        fault;
    logic        alert;
    logic        warn;
    logic        out_en;
    logic        climit;
    logic        latched;
    logic [7:0]  action;
    logic [15:0] lv;
    logic [15:0] warn_lim;
    logic [15:0] unit;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        oc_meta;
    logic        oc_sync;
  } ocf_top_s;

endpackage : ocf_pkg

// >>> hw/ocf_delay_timer.sv
// Delay timer counting two to the power of a code in time units of programmable length
`timescale 1ns/1ps
`include "ocf_defines.svh"

module ocf_delay_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic [2:0]  code_i,
  input  wire logic [15:0] unit_i,
  output logic             done_o,
  output logic             busy_o
);

  ocf_pkg::ocf_timer_s q;
  ocf_pkg::ocf_timer_s d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (stop_i) begin
      d.busy = 1'b0;
    end else if (start_i) begin
      d.busy  = 1'b1;
      d.units = 8'h01 << code_i;
      d.cyc   = unit_i;
    end else if (q.busy) begin
      // A unit of zero length behaves as one cycle
      if (q.cyc <= 16'h0001) begin
        if (q.units <= 8'h01) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end else begin
          d.units = q.units - 8'h01;
          d.cyc   = unit_i;
        end
      end else begin
        d.cyc = q.cyc - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;
  assign busy_o = q.busy;

endmodule : ocf_delay_timer

// >>> hw/ocf_top.sv
// Over-current fault response, retry sequencing and threshold commands
`timescale 1ns/1ps
`include "ocf_defines.svh"

module ocf_top (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        CMD_WR_I,
  input  wire logic        CMD_RD_I,
  input  wire logic [7:0]  CMD_CODE_I,
  input  wire logic [15:0] CMD_DATA_I,
  input  wire logic        CLEAR_FAULT_I,
  input  wire logic        OC_DETECT_I,
  input  wire logic        ON_I,
  input  wire logic        BIAS_OK_I,
  input  wire logic        OTHER_FAULT_I,
  input  wire logic [15:0] VOUT_SAMPLE_I,
  input  wire logic [15:0] IOUT_SAMPLE_I,
  input  wire logic        IOUT_VALID_I,
  output logic             OUT_EN_O,
  output logic             CURR_LIMIT_O,
  output logic             LATCHED_OFF_O,
  output logic             FAULT_STATUS_O,
  output logic             WARN_STATUS_O,
  output logic             ALERT_O,
  output logic [15:0]      LV_THRESHOLD_O,
  output logic [15:0]      WARN_THRESHOLD_O,
  output logic [15:0]      RD_DATA_O,
  output logic             RD_VALID_O
);

  ocf_pkg::ocf_top_s q;
  ocf_pkg::ocf_top_s d;

  logic              tmr_start;
  logic              tmr_stop;
  logic              tmr_done;
  logic              tmr_busy;
  logic              oc;
  logic              stop_req;
  logic              retry_ok;
  logic              low_vout;
  logic              warn_hit;
  logic signed [47:0] iout_lin;
  logic signed [47:0] warn_lin;
  logic [2:0]        retries;
  logic [2:0]        delay_code;
  ocf_pkg::ocf_mode_e mode;

  // Linear format: 5-bit signed exponent over 11-bit signed mantissa, scaled to a common fixed point
  function automatic logic signed [47:0] lin_val(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0]         sh;
    m  = 48'(signed'(w[10:0]));
    // Offset the signed exponent by 16 so every shift is to the left
    sh = {w[15], w[15:11]} + 6'h10;
    return m <<< sh;
  endfunction : lin_val

  // One timer serves both the limiting phase and the retry gap
  ocf_delay_timer u_timer (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .start_i (tmr_start),
    .stop_i  (tmr_stop),
    .code_i  (delay_code),
    .unit_i  (q.unit),
    .done_o  (tmr_done),
    .busy_o  (tmr_busy)
  );

  always_comb begin
    // Fault seen only after the two-flop synchroniser
    oc         = q.oc_sync;
    // Field decode of the stored action byte
    mode       = ocf_pkg::ocf_mode_e'(q.action[`OCF_RESP_HI:`OCF_RESP_LO]);
    retries    = q.action[`OCF_RETRY_HI:`OCF_RETRY_LO];
    delay_code = q.action[`OCF_DELAY_HI:`OCF_DELAY_LO];
    // Any stop source drops the output at once
    stop_req   = !ON_I || !BIAS_OK_I || OTHER_FAULT_I;
    // Unsigned compare, strictly below the threshold
    low_vout   = VOUT_SAMPLE_I < q.lv;
    iout_lin   = lin_val(IOUT_SAMPLE_I);
    warn_lin   = lin_val(q.warn_lim);
    warn_hit   = IOUT_VALID_I && (iout_lin > warn_lin);
    // Restart budget: none, endless, or bounded by the attempt count
    if (retries == `OCF_RETRY_NONE) begin
      retry_ok = 1'b0;
    end else if (retries == `OCF_RETRY_ENDLESS) begin
      retry_ok = 1'b1;
    end else begin
      retry_ok = q.attempts < retries;
    end
  end

  always_comb begin
    d          = q;
    d.rd_valid = 1'b0;
    // Two-flop synchroniser for the asynchronous comparator pin
    d.oc_meta  = OC_DETECT_I;
    d.oc_sync  = q.oc_meta;
    // Timer requests default low each cycle
    tmr_start  = 1'b0;
    tmr_stop   = 1'b0;

    // Command writes
    // Read-only and unknown codes fall through unchanged
    if (CMD_WR_I) begin
      case (CMD_CODE_I)
        `OCF_CMD_ACTION: begin
          d.action = CMD_DATA_I[7:0];
        end
        `OCF_CMD_LV_THRESH: begin
          d.lv = CMD_DATA_I;
        end
        `OCF_CMD_WARN: begin
          d.warn_lim = CMD_DATA_I;
        end
        `OCF_CMD_UNIT: begin
          d.unit = CMD_DATA_I;
        end
        default: begin
        end
      endcase
    end

    // Command reads; unmapped codes answer zero
    // Data answers one cycle later with a one-cycle valid pulse
    if (CMD_RD_I) begin
      d.rd_valid = 1'b1;
      case (CMD_CODE_I)
        `OCF_CMD_ACTION: begin
          d.rd_data = {8'h00, q.action};
        end
        `OCF_CMD_LV_THRESH: begin
          d.rd_data = q.lv;
        end
        `OCF_CMD_WARN: begin
          d.rd_data = q.warn_lim;
        end
        `OCF_CMD_UNIT: begin
          d.rd_data = q.unit;
        end
        `OCF_CMD_STATUS: begin
          d.rd_data                   = 16'h0000;
          d.rd_data[`OCF_STAT_FAULT]  = q.fault;
          d.rd_data[`OCF_STAT_WARN]   = q.warn;
          d.rd_data[`OCF_STAT_LATCHED] = q.latched;
          d.rd_data[`OCF_STAT_OUT_EN] = q.out_en;
          d.rd_data[`OCF_STAT_LIMIT]  = q.climit;
          d.rd_data[`OCF_STAT_ATT_LO +: 3] = q.attempts;
        end
        default: begin
          d.rd_data = 16'h0000;
        end
      endcase
    end

    // Sticky flags: a new event in the clearing cycle wins
    if (CLEAR_FAULT_I) begin
      d.fault = 1'b0;
      d.warn  = 1'b0;
    end
    if (oc) begin
      d.fault = 1'b1;
    end
    if (warn_hit) begin
      d.warn = 1'b1;
    end
    // Alert follows either sticky flag
    d.alert = d.fault || d.warn;

    // Stop sources override every state and restore the full retry budget
    if (stop_req) begin
      d.st       = ocf_pkg::ST_OFF;
      d.attempts = 3'h0;
      tmr_stop   = 1'b1;
    end else begin
      if (CLEAR_FAULT_I) begin
        d.attempts = 3'h0;
      end
      case (q.st)
        // Power-up or after a stop: enable on the next edge
        ocf_pkg::ST_OFF: begin
          d.st = ocf_pkg::ST_RUN;
        end
        // Normal operation; a synchronised fault picks the response
        ocf_pkg::ST_RUN: begin
          if (oc) begin
            case (mode)
              ocf_pkg::MODE_IGNORE: begin
                // Limit indefinitely, voltage ignored
                d.st = ocf_pkg::ST_LIMIT;
              end
              ocf_pkg::MODE_COND_CC: begin
                d.st = ocf_pkg::ST_LIMIT;
              end
              ocf_pkg::MODE_DELAY: begin
                d.st      = ocf_pkg::ST_LIMIT;
                tmr_start = 1'b1;
              end
              default: begin
                d.st = ocf_pkg::ST_HOLD;
              end
            endcase
          end
        end
        // Limiting: leave on fault loss, a switch to resume-when-ok mode or a shutdown condition
        ocf_pkg::ST_LIMIT: begin
          if (!oc) begin
            d.st     = ocf_pkg::ST_RUN;
            tmr_stop = 1'b1;
          end else if (mode == ocf_pkg::MODE_RESUME) begin
            // A switch to resume-when-ok mid-limit stops limiting at once
            d.st     = ocf_pkg::ST_HOLD;
            tmr_stop = 1'b1;
          end else if ((mode == ocf_pkg::MODE_COND_CC && low_vout) ||
                       (mode == ocf_pkg::MODE_DELAY && tmr_done)) begin
            // Shutdown: retry while the budget allows, else latch off
            if (retry_ok) begin
              d.st      = ocf_pkg::ST_WAIT;
              tmr_start = 1'b1;
            end else begin
              d.st     = ocf_pkg::ST_LATCH;
              tmr_stop = 1'b1;
            end
          end
        end
        // Output off for one delay before the next restart
        ocf_pkg::ST_WAIT: begin
          if (tmr_done) begin
            d.st = ocf_pkg::ST_RUN;
            // Endless retry never counts, so the counter cannot wrap
            if (retries != `OCF_RETRY_ENDLESS && !CLEAR_FAULT_I) begin
              d.attempts = q.attempts + 3'h1;
            end
          end
        end
        // Latched off until the host clears the fault or a stop source forces the off state
        ocf_pkg::ST_LATCH: begin
          if (CLEAR_FAULT_I) begin
            d.st = ocf_pkg::ST_OFF;
          end
        end
        // Resume-when-ok: off only while the fault lasts
        ocf_pkg::ST_HOLD: begin
          if (!oc) begin
            d.st = ocf_pkg::ST_RUN;
          end
        end
        default: begin
          d.st = ocf_pkg::ST_OFF;
        end
      endcase
    end

    // Outputs follow the next state so every port leaves a flip-flop
    d.out_en  = (d.st == ocf_pkg::ST_RUN) || (d.st == ocf_pkg::ST_LIMIT);
    d.climit  = d.st == ocf_pkg::ST_LIMIT;
    d.latched = d.st == ocf_pkg::ST_LATCH;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      // Clear everything, then load the power-on configuration
      q          <= '0;
      q.st       <= ocf_pkg::ST_OFF;
      q.action   <= `OCF_ACTION_RST;
      q.lv       <= `OCF_LV_RST;
      q.warn_lim <= `OCF_WARN_RST;
      q.unit     <= `OCF_UNIT_RST;
    end else begin
      q <= d;
    end
  end

  // Every port comes straight from a register
  assign OUT_EN_O         = q.out_en;
  assign CURR_LIMIT_O     = q.climit;
  assign LATCHED_OFF_O    = q.latched;
  assign FAULT_STATUS_O   = q.fault;
  assign WARN_STATUS_O    = q.warn;
  assign ALERT_O          = q.alert;
  assign LV_THRESHOLD_O   = q.lv;
  assign WARN_THRESHOLD_O = q.warn_lim;
  assign RD_DATA_O        = q.rd_data;
  assign RD_VALID_O       = q.rd_valid;

endmodule : ocf_top

// >>> verif/ocf_monitor.sv
// Port-level checks for the over-current fault block
`timescale 1ns/1ps
module ocf_monitor (
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic        CMD_WR_I,
  input wire logic        CMD_RD_I,
  input wire logic [7:0]  CMD_CODE_I,
  input wire logic [15:0] CMD_DATA_I,
  input wire logic        CLEAR_FAULT_I,
  input wire logic        ON_I,
  input wire logic        BIAS_OK_I,
  input wire logic        OTHER_FAULT_I,
  input wire logic        OUT_EN_O,
  input wire logic        CURR_LIMIT_O,
  input wire logic        LATCHED_OFF_O,
  input wire logic        FAULT_STATUS_O,
  input wire logic        WARN_STATUS_O,
  input wire logic        ALERT_O,
  input wire logic [15:0] LV_THRESHOLD_O,
  input wire logic [15:0] WARN_THRESHOLD_O,
  input wire logic [15:0] RD_DATA_O,
  input wire logic        RD_VALID_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  property p_lv_wr;
    CMD_WR_I && CMD_CODE_I == 8'h48 |=> LV_THRESHOLD_O == $past(CMD_DATA_I);
  endproperty
  a_lv_wr: assert property (p_lv_wr) else $error("low-voltage threshold not stored");
  property p_warn_wr;
    CMD_WR_I && CMD_CODE_I == 8'h4a |=> WARN_THRESHOLD_O == $past(CMD_DATA_I);
  endproperty
  a_warn_wr: assert property (p_warn_wr) else $error("warning threshold not stored");
  property p_rd_lv;
    CMD_RD_I && CMD_CODE_I == 8'h48 |=> RD_VALID_O && RD_DATA_O == $past(LV_THRESHOLD_O);
  endproperty
  a_rd_lv: assert property (p_rd_lv) else $error("threshold readback wrong");
  property p_latch_off;
    LATCHED_OFF_O |-> !OUT_EN_O && !CURR_LIMIT_O;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("output on while latched");
  property p_fault_set;
    $rose(CURR_LIMIT_O) |-> FAULT_STATUS_O;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("limit without fault flag");
  property p_alert;
    ALERT_O == (FAULT_STATUS_O || WARN_STATUS_O);
  endproperty
  a_alert: assert property (p_alert) else $error("alert disagrees with flags");
  property p_sticky;
    FAULT_STATUS_O && !CLEAR_FAULT_I |=> FAULT_STATUS_O;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag lost without clear");
  property p_stop;
    !ON_I || !BIAS_OK_I || OTHER_FAULT_I |-> ##[1:2] !OUT_EN_O;
  endproperty
  a_stop: assert property (p_stop) else $error("output stayed on after stop");
  c_latch: cover property ($rose(LATCHED_OFF_O));
  c_limit: cover property ($rose(CURR_LIMIT_O));
  c_read: cover property (RD_VALID_O);
endmodule : ocf_monitor

bind ocf_top ocf_monitor ocf_monitor_inst (.MCLK_I(MCLK_I), .RST_I(RST_I), .CMD_WR_I(CMD_WR_I),
  .CMD_RD_I(CMD_RD_I), .CMD_CODE_I(CMD_CODE_I), .CMD_DATA_I(CMD_DATA_I), .CLEAR_FAULT_I(CLEAR_FAULT_I),
  .ON_I(ON_I), .BIAS_OK_I(BIAS_OK_I), .OTHER_FAULT_I(OTHER_FAULT_I), .OUT_EN_O(OUT_EN_O),
  .CURR_LIMIT_O(CURR_LIMIT_O), .LATCHED_OFF_O(LATCHED_OFF_O), .FAULT_STATUS_O(FAULT_STATUS_O),
  .WARN_STATUS_O(WARN_STATUS_O), .ALERT_O(ALERT_O), .LV_THRESHOLD_O(LV_THRESHOLD_O),
  .WARN_THRESHOLD_O(WARN_THRESHOLD_O), .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O));

// >>> verif/ocf_host_model.sv
// Host controller issuing command writes and reads
`timescale 1ns/1ps
module ocf_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_valid_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [7:0]       code_o,
  output logic [15:0]      data_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = 8'h00;
    data_o = 16'h0000;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    code_o <= c;
    data_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    data_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    @(posedge clk_i);
    rd_o <= 1'b1;
    code_o <= c;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rd_data_i;
    ok = rd_valid_i;
  endtask : rd
endmodule : ocf_host_model

// >>> verif/tb_top.sv
// Self-checking bench for the over-current fault block
`timescale 1ns/1ps
`include "ocf_defines.svh"
module tb_top;
  logic        MCLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        CLEAR_FAULT_I = 1'b0;
  logic        OC_DETECT_I = 1'b0;
  logic        ON_I = 1'b1;
  logic        BIAS_OK_I = 1'b1;
  logic        OTHER_FAULT_I = 1'b0;
  logic        IOUT_VALID_I = 1'b0;
  logic [15:0] VOUT_SAMPLE_I = 16'h2000;
  logic [15:0] IOUT_SAMPLE_I = 16'h0000;
  logic        wr, rd, rd_valid, out_en, climit, latched, fault, warn, alert;
  logic [7:0]  code;
  logic [15:0] data, rd_data, lv, wlim;
  int          num_errors = 0;
  int          check_count = 0;
  always #2.5 MCLK_I = ~MCLK_I;
  ocf_host_model host_inst (.clk_i(MCLK_I), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .wr_o(wr), .rd_o(rd),
    .code_o(code), .data_o(data));
  ocf_top ocf_top_inst (.MCLK_I(MCLK_I), .RST_I(RST_I), .CMD_WR_I(wr), .CMD_RD_I(rd), .CMD_CODE_I(code),
    .CMD_DATA_I(data), .CLEAR_FAULT_I(CLEAR_FAULT_I), .OC_DETECT_I(OC_DETECT_I), .ON_I(ON_I),
    .BIAS_OK_I(BIAS_OK_I), .OTHER_FAULT_I(OTHER_FAULT_I), .VOUT_SAMPLE_I(VOUT_SAMPLE_I),
    .IOUT_SAMPLE_I(IOUT_SAMPLE_I), .IOUT_VALID_I(IOUT_VALID_I), .OUT_EN_O(out_en), .CURR_LIMIT_O(climit),
    .LATCHED_OFF_O(latched), .FAULT_STATUS_O(fault), .WARN_STATUS_O(warn), .ALERT_O(alert),
    .LV_THRESHOLD_O(lv), .WARN_THRESHOLD_O(wlim), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid));
  task automatic final_report;
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_out(input logic v, output int n);
    n = 0;
    while (out_en !== v) begin
      @(posedge MCLK_I);
      #1;
      n++;
      if (n > 3000) begin
        num_errors++;
        final_report();
      end
    end
  endtask : wait_out
  task automatic act(input logic [1:0] m, input logic [2:0] r, input logic [2:0] dl);
    host_inst.wr(`OCF_CMD_ACTION, {8'h00, m, r, dl});
  endtask : act
  task automatic clr;
    int n;
    @(posedge MCLK_I) OC_DETECT_I <= 1'b0;
    repeat (4) @(posedge MCLK_I);
    CLEAR_FAULT_I <= 1'b1;
    @(posedge MCLK_I) CLEAR_FAULT_I <= 1'b0;
    wait_out(1'b1, n);
  endtask : clr
  task automatic t_regs;
    logic [15:0] d;
    logic        ok;
    host_inst.rd(`OCF_CMD_LV_THRESH, d, ok);
    chk("lv_reset", d, 16'h0000);
    host_inst.rd(`OCF_CMD_WARN, d, ok);
    chk("warn_reset", d, 16'h7bff);
    host_inst.wr(`OCF_CMD_LV_THRESH, 16'h1000);
    host_inst.wr(`OCF_CMD_WARN, 16'habcd);
    host_inst.wr(`OCF_CMD_UNIT, 16'h0004);
    host_inst.rd(`OCF_CMD_LV_THRESH, d, ok);
    chk("lv", d, 16'h1000);
    host_inst.rd(`OCF_CMD_WARN, d, ok);
    chk("warn", d, 16'habcd);
    host_inst.rd(`OCF_CMD_UNIT, d, ok);
    chk("unit", d, 16'h0004);
    host_inst.rd(8'h55, d, ok);
    chk("unmapped", {ok, d[14:0]}, 16'h8000);
  endtask : t_regs
  task automatic t_no_retry;
    int n;
    act(2'h2, 3'h0, 3'h0);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b1;
    wait_out(1'b0, n);
    repeat (20) @(posedge MCLK_I);
    chk("latched", {15'h0000, latched}, 16'h0001);
    chk("stays_off", {15'h0000, out_en}, 16'h0000);
    clr();
  endtask : t_no_retry
  task automatic t_retry_two;
    int          n;
    logic [15:0] d;
    logic        ok;
    act(2'h2, 3'h2, 3'h1);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_out(1'b0, n);
      wait_out(1'b1, n);
      chk("gap", 16'(n >= 6 && n <= 11), 16'h0001);
    end
    wait_out(1'b0, n);
    repeat (3) @(posedge MCLK_I);
    host_inst.rd(`OCF_CMD_STATUS, d, ok);
    chk("latched_status", d, 16'h0045);
    clr();
    host_inst.rd(`OCF_CMD_STATUS, d, ok);
    chk("cleared_status", d, 16'h0008);
  endtask : t_retry_two
  task automatic t_endless;
    int n;
    act(2'h2, 3'h7, 3'h0);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b1;
    repeat (8) begin
      wait_out(1'b0, n);
      wait_out(1'b1, n);
    end
    chk("not_latched", {15'h0000, latched}, 16'h0000);
    @(posedge MCLK_I) ON_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    chk("off_cmd", {15'h0000, out_en}, 16'h0000);
    @(posedge MCLK_I) ON_I <= 1'b1;
    clr();
  endtask : t_endless
  task automatic t_resume;
    int n;
    act(2'h3, 3'h0, 3'h0);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b1;
    wait_out(1'b0, n);
    repeat (10) @(posedge MCLK_I);
    chk("hold_no_latch", {15'h0000, latched}, 16'h0000);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b0;
    wait_out(1'b1, n);
    chk("resume", 16'(n <= 8), 16'h0001);
    clr();
  endtask : t_resume
  task automatic t_cond_cc;
    int n;
    act(2'h1, 3'h0, 3'h0);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b1;
    repeat (40) @(posedge MCLK_I);
    chk("cc_limit", {14'h0000, climit, out_en}, 16'h0003);
    @(posedge MCLK_I) VOUT_SAMPLE_I <= 16'h0800;
    wait_out(1'b0, n);
    chk("lv_trip", 16'(n <= 4), 16'h0001);
    @(posedge MCLK_I) VOUT_SAMPLE_I <= 16'h2000;
    clr();
  endtask : t_cond_cc
  task automatic t_misc;
    int          n;
    logic [15:0] d;
    logic        ok;
    act(2'h0, 3'h1, 3'h0);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b1;
    repeat (40) @(posedge MCLK_I);
    #1;
    chk("ignore_limit", {13'h0000, climit, out_en, latched}, 16'h0006);
    chk("ignore_fault", {14'h0000, fault, alert}, 16'h0003);
    clr();
    act(2'h2, 3'h2, 3'h0);
    @(posedge MCLK_I) OC_DETECT_I <= 1'b1;
    wait_out(1'b0, n);
    wait_out(1'b1, n);
    @(posedge MCLK_I) ON_I <= 1'b0;
    @(posedge MCLK_I) ON_I <= 1'b1;
    host_inst.rd(`OCF_CMD_STATUS, d, ok);
    chk("off_clears_count", {13'h0000, d[7:5]}, 16'h0000);
    clr();
    @(posedge MCLK_I);
    IOUT_SAMPLE_I <= 16'h0000;
    IOUT_VALID_I  <= 1'b1;
    @(posedge MCLK_I) IOUT_VALID_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    #1;
    chk("warn_below", {14'h0000, warn, alert}, 16'h0000);
    @(posedge MCLK_I);
    IOUT_SAMPLE_I <= 16'h0801;
    IOUT_VALID_I  <= 1'b1;
    @(posedge MCLK_I) IOUT_VALID_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    #1;
    chk("warn_above", {14'h0000, warn, alert}, 16'h0003);
    @(posedge MCLK_I) CLEAR_FAULT_I <= 1'b1;
    @(posedge MCLK_I) CLEAR_FAULT_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    #1;
    chk("warn_clear", {14'h0000, warn, alert}, 16'h0000);
    @(posedge MCLK_I) RST_I <= 1'b1;
    repeat (3) @(posedge MCLK_I);
    #1;
    chk("rst_lv", lv, 16'h0000);
    chk("rst_warn", wlim, 16'h7bff);
    chk("rst_out", {15'h0000, out_en}, 16'h0000);
    @(posedge MCLK_I) RST_I <= 1'b0;
    wait_out(1'b1, n);
  endtask : t_misc
  initial begin
    repeat (20) @(posedge MCLK_I);
    RST_I <= 1'b0;
    t_regs();
    t_no_retry();
    t_retry_two();
    t_endless();
    t_resume();
    t_cond_cc();
    t_misc();
    final_report();
  end
endmodule : tb_top
